// file: rtl/gpio_port.sv
// General purpose pin block: five bit pins and a strobed eight-bit byte bus.
// What this block does
// - Five bit pins plus eight-line byte bus.
// - All thirteen pins are inputs after reset.
// - Bit pins individually; bus as one byte.
// - Each bit pin has own direction.
// - Bus transfers use low strobe, minimum width.
// - Pin four strobes byte capture in.
// - Pin five strobes byte driven out.
// - Pin one read as frame start mark.
// - Pin two read as low battery flag.
// - Pin three high powers card and display.
// - Pin three input lets external circuit drive.
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int STROBE_CYCLES = `STROBE_LOW_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire bit_ctrl_t  bit_ctrl_in,
  input  wire bus_req_t   bus_req_in,
  input  wire logic [4:0] bit_pin_in,
  input  wire logic [7:0] byte_bus_lines_in,
  output logic [4:0]      bit_pin_out,
  output logic [4:0]      bit_pin_oe_out,
  output logic [7:0]      byte_bus_lines_out,
  output logic [7:0]      byte_bus_lines_oe_out,
  output logic [4:0]      bit_level_out,
  output logic            frame_mark_out,
  output logic            battery_low_out,
  output logic            peripheral_power_out,
  output bus_resp_t       bus_resp_out
);
  localparam int CW = $clog2(STROBE_CYCLES + 1);

  typedef struct packed {
    strobe_state_t fsm;
    logic [CW-1:0] count;
    logic [4:0]    pin_out;
    logic [4:0]    pin_oe;
    logic [7:0]    bus_out;
    logic [7:0]    bus_oe;
    logic [4:0]    bit_level;
    logic          frame_mark;
    logic          battery_low;
    logic          power;
    bus_resp_t     resp;
  } port_state_t;

  port_state_t state;
  port_state_t next_state;
  logic [12:0] sync_level;
  logic [4:0]  bit_sync;
  logic [7:0]  bus_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Both transfer kinds share one low time, so the end test lives in one place.
  function automatic logic strobe_done(input logic [CW-1:0] ticks);
    return ticks == CW'(STROBE_CYCLES - 1);
  endfunction

  // Places the strobe of the running transfer and parks the level of the other
  // strobe pin high. Software may have left that pin as a low output, and the
  // external latches would then see a read and a write strobe at once.
  function automatic port_state_t drive_strobe(input port_state_t s,
                                               input logic        read_side,
                                               input logic        low);
    port_state_t r;
    r = s;
    if (read_side) begin
      r.pin_oe[`BIT_READ_STROBE]   = 1'b1;
      r.pin_out[`BIT_READ_STROBE]  = ~low;
      r.pin_out[`BIT_WRITE_STROBE] = 1'b1;
    end else begin
      r.pin_oe[`BIT_WRITE_STROBE]  = 1'b1;
      r.pin_out[`BIT_WRITE_STROBE] = ~low;
      r.pin_out[`BIT_READ_STROBE]  = 1'b1;
    end
    return r;
  endfunction

  // Reset image of the whole block. Every enable is low, so no pin fights the
  // external circuit while the processor is still starting up.
  function automatic port_state_t reset_state();
    port_state_t r;
    r             = '0;
    r.fsm         = ST_IDLE;
    r.count       = '0;
    r.pin_oe      = `BIT_DIR_RESET;
    r.pin_out     = `BIT_OUT_RESET;
    r.bus_oe      = '0;
    r.bus_out     = `BUS_OUT_RESET;
    r.bit_level   = '0;
    r.frame_mark  = 1'b0;
    r.battery_low = 1'b0;
    r.power       = 1'b0;
    r.resp        = '0;
    return r;
  endfunction

  gpio_pin_sync #(
    .WIDTH(13)
  ) u_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .pin_in   ({byte_bus_lines_in, bit_pin_in}),
    .level_out(sync_level)
  );

  assign bit_sync = sync_level[4:0];
  assign bus_sync = sync_level[12:5];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.resp.read_done = 1'b0;
    // Each pin follows its own direction and level bit from software, except the two strobe pins while a transfer runs.
    next_state.pin_oe  = bit_ctrl_in.dir;
    next_state.pin_out = bit_ctrl_in.level;
    next_state.bit_level = bit_sync;
    next_state.frame_mark  = bit_sync[`BIT_FRAME_MARK];
    next_state.battery_low = bit_sync[`BIT_BATTERY_STATUS];
    // Power follows the driven level when an output, else the external circuit.
    next_state.power = bit_ctrl_in.dir[`BIT_PERIPHERAL_POWER] ?
                       bit_ctrl_in.level[`BIT_PERIPHERAL_POWER] :
                       bit_sync[`BIT_PERIPHERAL_POWER];
    unique case (state.fsm)
      ST_IDLE: begin
        next_state.bus_oe    = '0;
        next_state.resp.busy = 1'b0;
        // Read wins a simultaneous request so the strobes never overlap.
        if (bus_req_in.read_req) begin
          next_state           = drive_strobe(next_state, 1'b1, 1'b1);
          next_state.fsm       = ST_READ;
          next_state.count     = '0;
          next_state.resp.busy = 1'b1;
        end else if (bus_req_in.write_req) begin
          next_state           = drive_strobe(next_state, 1'b0, 1'b1);
          next_state.fsm       = ST_WRITE;
          next_state.count     = '0;
          next_state.resp.busy = 1'b1;
          next_state.bus_out   = bus_req_in.write_data;
          next_state.bus_oe    = 8'hff;
        end
      end
      ST_READ: begin
        next_state.bus_oe = '0;
        next_state.count  = state.count + 1'b1;
        if (strobe_done(state.count)) begin
          // Strobe ends after the minimum low time; the bus byte is caught here.
          next_state                = drive_strobe(next_state, 1'b1, 1'b0);
          next_state.fsm            = ST_IDLE;
          next_state.resp.read_data = bus_sync;
          next_state.resp.read_done = 1'b1;
        end else begin
          next_state = drive_strobe(next_state, 1'b1, 1'b1);
        end
      end
      ST_WRITE: begin
        next_state.bus_oe = 8'hff;
        next_state.count  = state.count + 1'b1;
        if (strobe_done(state.count)) begin
          // Data stays driven one cycle past the rising edge for hold at the latch.
          next_state     = drive_strobe(next_state, 1'b0, 1'b0);
          next_state.fsm = ST_IDLE;
        end else begin
          next_state = drive_strobe(next_state, 1'b0, 1'b1);
        end
      end
      default: begin
        next_state.fsm = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= reset_state();
    end else begin
      state <= next_state;
    end
  end

  assign bit_pin_out           = state.pin_out;
  assign bit_pin_oe_out        = state.pin_oe;
  assign byte_bus_lines_out    = state.bus_out;
  assign byte_bus_lines_oe_out = state.bus_oe;
  assign bit_level_out         = state.bit_level;
  assign frame_mark_out        = state.frame_mark;
  assign battery_low_out       = state.battery_low;
  assign peripheral_power_out  = state.power;
  assign bus_resp_out          = state.resp;
endmodule

// file: pkg/gpio_port_params.svh
// Constants for the general purpose pin block: widths, reset values and strobe timing.
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH
`define BIT_PIN_COUNT        5
`define BYTE_BUS_WIDTH       8
`define BIT_DIR_RESET        5'h00
`define BIT_OUT_RESET        5'h1f
`define BUS_OUT_RESET        8'h00
`define STROBE_MIN_NS        50
`define CLK_PERIOD_NS        5
`define STROBE_LOW_CYCLES    ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_FRAME_MARK       0
`define BIT_BATTERY_STATUS   1
`define BIT_PERIPHERAL_POWER 2
`define BIT_READ_STROBE      3
`define BIT_WRITE_STROBE     4
`endif

// file: pkg/gpio_port_pkg.sv
// Types shared by the general purpose pin block.
package gpio_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } strobe_state_t;

  typedef struct packed {
    logic [4:0] dir;
    logic [4:0] level;
  } bit_ctrl_t;

  typedef struct packed {
    logic       read_req;
    logic       write_req;
    logic [7:0] write_data;
  } bus_req_t;

  typedef struct packed {
    logic       busy;
    logic       read_done;
    logic [7:0] read_data;
  } bus_resp_t;
endpackage

// file: rtl/gpio_pin_sync.sv
// Three-stage pin synchroniser with agreement filter for a group of inputs.
`timescale 1ns/100ps
module gpio_pin_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state    = state;
    next_state.s1 = pin_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    for (int i = 0; i < WIDTH; i++) begin
      // The first stage is never examined; only the later two vote.
      if (state.s2[i] == state.s3[i]) begin
        next_state.level[i] = state.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_out = state.level;
endmodule

// file: verif/bus_latch_model.sv
// External latch model on the byte bus.
`timescale 1ns/100ps
module bus_latch_model (
  input  wire logic       clk_in,
  input  wire logic [4:0] pin_oe_in,
  input  wire logic [4:0] pin_level_in,
  input  wire logic [7:0] bus_oe_in,
  input  wire logic [7:0] bus_drive_in,
  input  wire logic [7:0] read_byte_in,
  output logic      [7:0] bus_level_out,
  output logic      [7:0] write_seen_out
);
  logic [7:0] last = 8'h00;
  logic       wr_d = 1'b0;
  logic       wr_low;
  logic       rd_low;
  assign wr_low = pin_oe_in[4] & ~pin_level_in[4];
  assign rd_low = pin_oe_in[3] & ~pin_level_in[3];
  // The latch closes on the rising edge of the write strobe.
  always_ff @(posedge clk_in) begin
    wr_d <= wr_low;
    if (wr_d && !wr_low) begin
      write_seen_out <= bus_drive_in;
    end
    last <= bus_level_out;
  end
  // An undriven bus shows a changing pattern, never a stale byte.
  always_comb begin
    if (bus_oe_in == 8'hff) begin
      bus_level_out = bus_drive_in;
    end else if (rd_low) begin
      bus_level_out = read_byte_in;
    end else begin
      bus_level_out = ~last;
    end
  end
endmodule

// file: verif/gpio_port_asserts.sv
// Port assertions for the pin block.
`timescale 1ns/100ps
module gpio_port_asserts
  import gpio_port_pkg::*;
#(parameter int STROBE_CYCLES = 10) (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire bit_ctrl_t  bit_ctrl_in,
  input wire bus_req_t   bus_req_in,
  input wire logic [4:0] bit_pin_out,
  input wire logic [4:0] bit_pin_oe_out,
  input wire logic [7:0] byte_bus_lines_out,
  input wire logic [7:0] byte_bus_lines_oe_out,
  input wire logic       peripheral_power_out,
  input wire bus_resp_t  bus_resp_out
);
  localparam int RD = STROBE_CYCLES + 1;
  logic idle, rd_low, wr_low;
  assign idle = !bus_resp_out.busy;
  assign rd_low = bit_pin_oe_out[3] && !bit_pin_out[3];
  assign wr_low = bit_pin_oe_out[4] && !bit_pin_out[4];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////
  a_reset_all_in: assert property (disable iff (1'b0) reset_in |=>
    bit_pin_oe_out == 5'h00 && byte_bus_lines_oe_out == 8'h00) else $error("pin driven in reset");
  a_read_done_time: assert property (idle && bus_req_in.read_req |-> ##RD
    bus_resp_out.read_done) else $error("read end late");
  a_read_strobe_low: assert property (bus_resp_out.read_done |-> bit_pin_out[3]
    && $past(rd_low)) else $error("read strobe shape");
  a_bus_quiet_read: assert property (rd_low |-> byte_bus_lines_oe_out == 8'h00)
    else $error("bus driven in read");
  a_strobe_excl: assert property (bus_resp_out.busy |-> !(rd_low && wr_low))
    else $error("both strobes low");
  a_write_drive: assert property (idle && bus_req_in.write_req && !bus_req_in.read_req |=>
    byte_bus_lines_oe_out == 8'hff && byte_bus_lines_out == $past(bus_req_in.write_data)
    && wr_low) else $error("write not driven");
  a_bit_follow: assert property (!$past(reset_in) |-> bit_pin_oe_out[2:0] ==
    $past(bit_ctrl_in.dir[2:0]) && bit_pin_out[2:0] == $past(bit_ctrl_in.level[2:0]))
    else $error("bit pin lag");
  a_power_level: assert property (bit_pin_oe_out[2] && $stable(bit_pin_out)
    && $stable(bit_pin_oe_out) |-> peripheral_power_out == bit_pin_out[2])
    else $error("power level");
  c_read: cover property (bus_resp_out.read_done);
  c_write: cover property (wr_low && bus_resp_out.busy);
  c_power: cover property (bit_pin_oe_out[2] && peripheral_power_out);
endmodule
bind gpio_port gpio_port_asserts #(.STROBE_CYCLES(STROBE_CYCLES)) chk (.clk_in, .reset_in,
  .bit_ctrl_in, .bus_req_in, .bit_pin_out, .bit_pin_oe_out, .byte_bus_lines_out,
  .byte_bus_lines_oe_out, .peripheral_power_out, .bus_resp_out);

// file: verif/tb_gpio_port.sv
// Self-checking bench for the pin block.
`timescale 1ns/100ps
module tb_gpio_port;
  import gpio_port_pkg::*;
  localparam int S = 10;
  logic      clk_in = 1'b0;
  logic      reset_in = 1'b1;
  bit_ctrl_t ctrl = '0;
  bus_req_t  req = '0;
  bus_resp_t resp;
  logic [4:0] ext = 5'h00, pin_in, pout, poe, lvl;
  logic [7:0] bin, bout, boe, rd_data = 8'h00, wr_seen;
  logic       fm, bat, pwr;
  int         num_errors = 0, samples_checked = 0;
  assign pin_in = (poe & pout) | (~poe & ext);
  initial forever #2.5 clk_in = ~clk_in;
  gpio_port #(.STROBE_CYCLES(S)) dut (.clk_in, .reset_in, .bit_ctrl_in(ctrl), .bus_req_in(req),
    .bit_pin_in(pin_in), .byte_bus_lines_in(bin), .bit_pin_out(pout), .bit_pin_oe_out(poe),
    .byte_bus_lines_out(bout), .byte_bus_lines_oe_out(boe), .bit_level_out(lvl),
    .frame_mark_out(fm), .battery_low_out(bat), .peripheral_power_out(pwr), .bus_resp_out(resp));
  bus_latch_model peer (.clk_in, .pin_oe_in(poe), .pin_level_in(pout), .bus_oe_in(boe),
    .bus_drive_in(bout), .read_byte_in(rd_data), .bus_level_out(bin),
    .write_seen_out(wr_seen));
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  function automatic logic pin(input int n);
    return ctrl.dir[n] ? ctrl.level[n] : ext[n];
  endfunction
  function automatic logic [4:0] pins();
    return (ctrl.dir & ctrl.level) | (~ctrl.dir & ext);
  endfunction
  task automatic xfer(input logic rd, input logic wr, input logic [7:0] d);
    int k, lows;
    logic done;
    logic [7:0] got;
    lows = 0;
    done = 1'b0;
    got = 8'h00;
    rd_data = d;
    req = '{read_req: rd, write_req: wr, write_data: d};
    tick(1);
    req = '0;
    for (k = 0; k < 40 && resp.busy; k++) begin
      lows += rd ? (poe[3] & ~pout[3]) : (poe[4] & ~pout[4]);
      if (resp.read_done) {done, got} = {1'b1, resp.read_data};
      tick(1);
    end
    if (k == 40) begin
      num_errors++;
      close_out();
    end
    check(8'(lows), 8'(S));
    check({7'h0, done}, {7'h0, rd});
    check(rd ? got : wr_seen, d);
    check(boe, 8'h00);
  endtask
  initial begin
    int i;
    void'($urandom(13201));
    tick(6);
    check({3'h0, poe}, 8'h00);
    check(boe, 8'h00);
    reset_in = 1'b0;
    for (i = 0; i < 30; i++) begin
      ctrl = (i == 0) ? '{dir: 5'h1f, level: 5'h00} : bit_ctrl_t'(10'($urandom));
      ext = 5'($urandom);
      tick(6);
      check({3'h0, poe}, {3'h0, ctrl.dir});
      check({3'h0, pout}, {3'h0, ctrl.level});
      check({7'h0, fm}, {7'h0, pin(0)});
      check({7'h0, bat}, {7'h0, pin(1)});
      check({7'h0, pwr}, {7'h0, pin(2)});
      check({3'h0, lvl}, {3'h0, pins()});
    end
    $display("bit pin test done");
    ctrl = '{dir: 5'h18, level: 5'h18};
    tick(2);
    for (i = 0; i < 12; i++) begin
      // One read runs with pin five left as a low output by software.
      ctrl = '{dir:   5'h18 | 5'($urandom),
               level: ((i == 2) ? 5'h08 : 5'h18) | 5'($urandom & 32'h7)};
      xfer(i % 3 != 1, i % 3 != 2, (i < 2) ? {8{i[0]}} : 8'($urandom));
    end
    $display("byte bus test done");
    ctrl = '{dir: 5'h1f, level: 5'h1f};
    req = '{read_req: 1'b0, write_req: 1'b1, write_data: 8'h5a};
    tick(3);
    req = '0;
    reset_in = 1'b1;
    tick(2);
    check({3'h0, poe}, 8'h00);
    check(boe, 8'h00);
    check({7'h0, resp.busy}, 8'h00);
    reset_in = 1'b0;
    tick(2);
    check({3'h0, poe}, {3'h0, ctrl.dir});
    $display("mid-run reset test done");
    close_out();
  end
endmodule
